// ===== verilog/rbbc_regs.svh
// Offsets, reset values, field positions and timing counts of the reset/boot block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef RBBC_REGS_SVH
`define RBBC_REGS_SVH
`define RBBC_CTRL_OFS      12'h000
`define RBBC_STAT_OFS      12'h004
`define RBBC_IRQ_STAT_OFS  12'h008
`define RBBC_IRQ_MASK_OFS  12'h00c
`define RBBC_BOOT_OFS      12'h010
`define RBBC_VMAP_OFS      12'h014
`define RBBC_WAKE_OFS      12'h018
// Control register fields
`define RBBC_CTRL_BOR_EN   0
`define RBBC_CTRL_MAIN_OSC 1
`define RBBC_CTRL_PLL_EN   2
`define RBBC_CTRL_RESET    3'h0
// Interrupt bits
`define RBBC_IRQ_BOD       0
`define RBBC_IRQ_WAKE      1
`define RBBC_IRQ_W         2
// Vector map codes
`define RBBC_VMAP_ROM      2'h0
`define RBBC_VMAP_SRAM     2'h1
`define RBBC_VMAP_EXT      2'h2
// Boot addresses
`define RBBC_BOOT_ADDR     32'h81000000
`define RBBC_CS_LOW_BASE   32'h80000000
`define RBBC_VEC_BASE      32'h00000000
// Timing counts in cycles
`define RBBC_WAKE_RC_CYC   4
`define RBBC_WAKE_MAIN_CYC 4096
`define RBBC_POR_WAKE_CYC  4096
`endif

// ===== verilog/rbbc_pkg.sv
// Types shared by the reset/boot block and its bench.
// Assumes the constants header is on the include path.
`include "rbbc_regs.svh"
package rbbc_pkg;
  typedef enum logic [3:0]
  {
    RBBC_ST_HOLD = 4'h1,
    RBBC_ST_WAIT = 4'h2,
    RBBC_ST_RUN  = 4'h4,
    RBBC_ST_WAKE = 4'h8
  } rbbc_state_t;
  typedef struct packed
  {
    logic       pin_n;
    logic       wdt;
    logic       por;
    logic       bod_reset;
  } rbbc_rst_src_t;
  typedef struct packed
  {
    logic [1:0] bus_width;
    logic       cs_swap;
    logic [1:0] vec_map;
  } rbbc_boot_cfg_t;
endpackage : rbbc_pkg

// ===== verilog/rbbc_top.sv
// Reset merge, wake-up timer, boot straps, vector map and brownout logic with AHB-Lite regs.
// Assumes hclk runs from the internal RC oscillator and hresetn is the power-on root reset.
//
// How it works
// - Pin, watchdog, power-on and brownout resets all feed one chip reset.
// - Any reset source starts the wake timer; chip reset holds until pin release, osc ok, count done.
// - On release, registers other than brownout enable, interrupt status/mask and boot straps are at reset values; fetch address is the bank-1 start address.
// - On a power-on boot the two straps are sampled and set one bus width for banks 0 and 1.
// - Address pins that the chosen width does not need are handed to general-purpose I/O.
// - After power-on the chip-select 0 and 1 windows are swapped; the image links low.
// - Booting from external memory maps vectors to external memory until software remaps.
// - The vector map selects boot ROM, SRAM or external memory at the vector base.
// - The first brownout stage raises an interrupt and a pollable status flag.
// - The second brownout stage resets the chip only when software enabled that source.
// - The brownout reset stays asserted as the supply falls, then power-on reset takes over.
// - Selected external interrupt inputs wake the processor from power-down.
// - Leaving sleep holds execution 4 cycles on the RC clock and 4096 on the main oscillator.
// - After power-up or wake the RC clock runs; main oscillator and PLL wait for software.
//
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`include "rbbc_regs.svh"
module rbbc_top #(
  parameter int NUM_EINT     = 4,
  parameter int WAKE_MAIN    = `RBBC_WAKE_MAIN_CYC,
  parameter int POR_WAKE     = `RBBC_POR_WAKE_CYC,
  parameter int ADDR_W       = 26
) (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic      [31:0]                 hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  input  wire logic                        ext_reset_n,
  input  wire logic                        wdt_reset,
  input  wire logic                        bod_stage1,
  input  wire logic                        bod_stage2,
  input  wire logic                        osc_running,
  input  wire logic                        boot_strap_high,
  input  wire logic                        boot_strap_low,
  input  wire logic [NUM_EINT-1:0]         eint,
  input  wire logic                        power_down,
  output logic                             chip_reset_n,
  output logic                             cpu_hold,
  output logic [31:0]                      fetch_addr,
  output logic [1:0]                       ext_bus_width,
  output logic                             cs_swap,
  output logic [1:0]                       vec_map,
  output logic [ADDR_W-1:0]                addr_gpio_sel,
  output logic                             main_osc_sel,
  output logic                             pll_sel,
  output logic                             irq
);
  import rbbc_pkg::*;

  localparam int CNT_W = 13;

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers: stage one is read only by stage two
  logic [5:0] sy1_q;
  logic [5:0] sy2_q;
  logic [NUM_EINT-1:0] ei1_q;
  logic [NUM_EINT-1:0] ei2_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sy1_q <= 6'h01;
      sy2_q <= 6'h01;
      ei1_q <= '0;
      ei2_q <= '0;
    end
    else
    begin
      sy1_q <= {boot_strap_high, boot_strap_low, osc_running, bod_stage2, bod_stage1,
                ext_reset_n};
      sy2_q <= sy1_q;
      ei1_q <= eint;
      ei2_q <= ei1_q;
    end
  end
  rbbc_rst_src_t src;
  assign src.pin_n     = sy2_q[0];
  assign src.wdt       = wdt_reset;
  assign src.por       = 1'b0;
  assign src.bod_reset = sy2_q[2];
  wire bod1_s   = sy2_q[1];
  wire osc_ok_s = sy2_q[3];

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [2:0]          ctrl_q;
  logic [1:0]          irq_stat_q;
  logic [1:0]          irq_mask_q;
  logic [1:0]          vmap_q;
  logic [NUM_EINT-1:0] wake_en_q;
  logic [1:0]          width_q;
  logic                por_boot_q;

  // Brownout reset gated by software enable; POR (hresetn) covers below the low point
  wire bod_rst_req = src.bod_reset & ctrl_q[`RBBC_CTRL_BOR_EN];
  wire any_rst     = ~src.pin_n | src.wdt | bod_rst_req | src.por;

  ////////////////////////////////////////////////////////////////////////////////
  // Wake-up timer and sequence
  rbbc_state_t st_q;
  rbbc_state_t st_d;
  logic [CNT_W-1:0] cnt_q;
  logic             osc_was_main_q;
  wire [CNT_W-1:0] por_lim  = CNT_W'(POR_WAKE);
  wire [CNT_W-1:0] wake_lim = osc_was_main_q ? CNT_W'(WAKE_MAIN)
                                             : CNT_W'(`RBBC_WAKE_RC_CYC);
  wire wake_evt = power_down & |(ei2_q & wake_en_q);
  // Only the entry into the wake hold latches the clock source
  wire wake_go  = wake_evt && (st_q == RBBC_ST_RUN);
  wire cnt_done = (st_q == RBBC_ST_WAIT) ? (cnt_q >= por_lim - 1'b1)
                                         : (cnt_q >= wake_lim - 1'b1);
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      RBBC_ST_HOLD: if (src.pin_n && osc_ok_s) st_d = RBBC_ST_WAIT;
      RBBC_ST_WAIT: if (cnt_done) st_d = RBBC_ST_RUN;
      RBBC_ST_RUN:  if (wake_evt) st_d = RBBC_ST_WAKE;
      RBBC_ST_WAKE: if (cnt_done) st_d = RBBC_ST_RUN;
      default:      st_d = RBBC_ST_HOLD;
    endcase
    if (any_rst)
      st_d = RBBC_ST_HOLD;
  end
  wire reset_chip = (st_d == RBBC_ST_HOLD) || (st_d == RBBC_ST_WAIT);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q  <= RBBC_ST_HOLD;
      cnt_q <= '0;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= (st_d != st_q || st_d == RBBC_ST_HOLD || st_d == RBBC_ST_RUN)
               ? '0 : cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  logic        wr_q;
  logic [11:0] wa_q;
  wire         acc    = hsel & hready & htrans[1];
  wire         wr_en  = wr_q;
  wire         w_ctrl = wr_en && (wa_q == `RBBC_CTRL_OFS);
  wire         w_ist  = wr_en && (wa_q == `RBBC_IRQ_STAT_OFS);
  wire         w_imk  = wr_en && (wa_q == `RBBC_IRQ_MASK_OFS);
  wire         w_vmap = wr_en && (wa_q == `RBBC_VMAP_OFS);
  wire         w_wake = wr_en && (wa_q == `RBBC_WAKE_OFS);
  wire [1:0]   evt    = {(st_q == RBBC_ST_WAKE) && cnt_done, bod1_s};
  wire [1:0]   ist_d  = evt | (irq_stat_q & ~(w_ist ? hwdata[1:0] : 2'h0));
  logic [31:0] rd_mux;
  wire  [11:0] ra     = haddr[11:0];
  wire         r_ctrl = (ra == `RBBC_CTRL_OFS);
  wire         r_stat = (ra == `RBBC_STAT_OFS);
  wire         r_ist  = (ra == `RBBC_IRQ_STAT_OFS);
  wire         r_imk  = (ra == `RBBC_IRQ_MASK_OFS);
  wire         r_boot = (ra == `RBBC_BOOT_OFS);
  wire         r_vmap = (ra == `RBBC_VMAP_OFS);
  wire         r_wake = (ra == `RBBC_WAKE_OFS);
  // Unmapped offsets read as zero
  always_comb
  begin
    rd_mux = 32'h0;
    if (r_ctrl)
      rd_mux = {29'h0, ctrl_q};
    else if (r_stat)
      rd_mux = {26'h0, st_q, bod1_s, src.bod_reset};
    else if (r_ist)
      rd_mux = {30'h0, irq_stat_q};
    else if (r_imk)
      rd_mux = {30'h0, irq_mask_q};
    else if (r_boot)
      rd_mux = {29'h0, por_boot_q, width_q};
    else if (r_vmap)
      rd_mux = {30'h0, vmap_q};
    else if (r_wake)
      rd_mux = 32'(wake_en_q);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q      <= 1'b0;
      wa_q      <= 12'h000;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_q      <= acc & hwrite;
      wa_q      <= haddr[11:0];
      hrdata    <= (acc & ~hwrite) ? rd_mux : 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software state; chip reset clears clock selects, vector map and wake enables, not the interrupt regs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q     <= `RBBC_CTRL_RESET;
      irq_stat_q <= 2'h0;
      irq_mask_q <= 2'h0;
      vmap_q     <= `RBBC_VMAP_EXT;
      wake_en_q  <= '0;
      osc_was_main_q <= 1'b0;
    end
    else
    begin
      irq_stat_q <= ist_d;
      if (w_imk)
        irq_mask_q <= hwdata[1:0];
      if (reset_chip)
      begin
        // Brownout enable kept, else its own reset would end mid-brownout
        ctrl_q[2:1] <= 2'h0;
        vmap_q <= `RBBC_VMAP_EXT;
        wake_en_q <= '0;
      end
      else
      begin
        if (w_ctrl)
          ctrl_q <= hwdata[2:0];
        if (w_vmap && hwdata[1:0] != 2'h3)
          vmap_q <= hwdata[1:0];
        if (w_wake)
          wake_en_q <= hwdata[NUM_EINT-1:0];
        if (wake_go)
        begin
          osc_was_main_q <= ctrl_q[`RBBC_CTRL_MAIN_OSC];
          ctrl_q[2:1]    <= 2'h0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Straps sampled once at power-on boot, on entry to the wait so width settles before release
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      width_q    <= 2'h0;
      por_boot_q <= 1'b1;
    end
    else if (por_boot_q && st_q == RBBC_ST_HOLD && st_d == RBBC_ST_WAIT)
    begin
      width_q    <= sy2_q[5:4];
      por_boot_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  rbbc_boot_cfg_t cfg;
  assign cfg.bus_width = width_q;
  assign cfg.cs_swap   = 1'b1;
  assign cfg.vec_map   = vmap_q;
  // Narrow buses need fewer address lines; upper ones go to GPIO
  wire [ADDR_W-1:0] gpio_d = (width_q == 2'h0) ? {{(ADDR_W-20){1'b1}}, 20'h0} :
                             (width_q == 2'h1) ? {{(ADDR_W-21){1'b1}}, 21'h0} :
                                                 {{(ADDR_W-22){1'b1}}, 22'h0};

  // Reset and hold, launched from the next state so they line up with it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      chip_reset_n <= 1'b0;
      cpu_hold     <= 1'b1;
    end
    else
    begin
      chip_reset_n <= ~reset_chip;
      cpu_hold     <= (st_d != RBBC_ST_RUN);
    end
  end

  // Boot configuration
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fetch_addr    <= `RBBC_BOOT_ADDR;
      ext_bus_width <= 2'h0;
      cs_swap       <= 1'b1;
      vec_map       <= `RBBC_VMAP_EXT;
      addr_gpio_sel <= '0;
    end
    else
    begin
      fetch_addr    <= `RBBC_BOOT_ADDR;
      ext_bus_width <= cfg.bus_width;
      cs_swap       <= cfg.cs_swap;
      vec_map       <= cfg.vec_map;
      addr_gpio_sel <= gpio_d;
    end
  end

  // Clock selects, forced off while the chip is held
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      main_osc_sel <= 1'b0;
      pll_sel      <= 1'b0;
    end
    else
    begin
      main_osc_sel <= ctrl_q[`RBBC_CTRL_MAIN_OSC] & ~reset_chip;
      pll_sel      <= ctrl_q[`RBBC_CTRL_PLL_EN] & ~reset_chip;
    end
  end

  // Interrupt from next status, so it tracks the sticky bits without extra lag
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(ist_d & irq_mask_q);
  end
endmodule : rbbc_top

// ===== test/rbbc_props.sv
// Assertions on the reset/boot block ports.
// Assumes binding into rbbc_top; one clock domain, hresetn root.
module rbbc_props #(
  parameter int WAKE_MAIN = 4096
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        ext_reset_n,
  input wire logic        wdt_reset,
  input wire logic        osc_running,
  input wire logic        chip_reset_n,
  input wire logic        cpu_hold,
  input wire logic [31:0] fetch_addr,
  input wire logic        cs_swap,
  input wire logic [1:0]  vec_map,
  input wire logic        main_osc_sel,
  input wire logic        pll_sel
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WAKE_LIM = WAKE_MAIN;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence wake_min_s;
    cpu_hold [*4];
  endsequence
  sequence wake_end_s;
    ##[1:WAKE_LIM] !cpu_hold;
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  boot_const_a: assert property (fetch_addr == 32'h81000000 && cs_swap)
    else $error("boot address or swap wrong");
  wdt_src_a: assert property (wdt_reset |-> ##[1:3] !chip_reset_n)
    else $error("watchdog gave no reset");
  pin_src_a: assert property ($fell(ext_reset_n) |-> ##[1:4] !chip_reset_n)
    else $error("pin gave no reset");
  release_cond_a: assert property ($rose(chip_reset_n) |->
    $past(osc_running, 3) && $past(ext_reset_n, 3)) else $error("reset left early");
  reset_hold_a: assert property (!chip_reset_n |-> cpu_hold && !main_osc_sel && !pll_sel)
    else $error("hold or clock select wrong in reset");
  boot_vec_a: assert property ($rose(chip_reset_n) |-> vec_map == 2'h2)
    else $error("vectors not external at boot");
  wake_len_a: assert property ($rose(cpu_hold) && chip_reset_n |-> wake_min_s ##0 wake_end_s)
    else $error("wake hold length wrong");
  wake_clk_a: assert property ($fell(cpu_hold) && chip_reset_n |-> !main_osc_sel && !pll_sel)
    else $error("clock select kept after wake");
endmodule : rbbc_props

// ===== test/rbbc_far.sv
// Oscillator model beside the block.
// Assumes the oscillator starts once power-on reset is released.
module rbbc_far #(
  parameter int OSC_DLY = 5
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      osc_running
);
  timeunit 1ns;
  timeprecision 100ps;
  int n_q;
  // Slow start so the hold on osc is seen
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) n_q <= 0;
    else if (n_q < OSC_DLY) n_q <= n_q + 1;
  assign osc_running = (n_q == OSC_DLY);
endmodule : rbbc_far

// ===== test/testbench.sv
// Bench for the reset/boot block: AHB-Lite tasks and sequenced tests.
// Assumes rbbc_pkg compiled first; wake and POR counts shortened.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import rbbc_pkg::*;
  localparam int WM = 16;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ext_reset_n = 1, wdt_reset = 0;
  logic bod_stage1 = 0, bod_stage2 = 0, sh = 1, sl = 0, power_down = 0, osc, hreadyout, hresp;
  logic [1:0] htrans = 0, bw, vm;
  logic [2:0] hsize = 0;
  logic [3:0] eint = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, fa, r;
  logic [25:0] gs;
  logic crn, hold, cs, mos, pll, irq;
  int mismatches = 0, num_checks = 0, n;
  always #12.5 hclk = ~hclk;
  rbbc_far i_rbbc_far (.hclk(hclk), .hresetn(hresetn), .osc_running(osc));
  rbbc_top #(.WAKE_MAIN(WM), .POR_WAKE(8)) i_rbbc_top (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_reset_n(ext_reset_n), .wdt_reset(wdt_reset), .bod_stage1(bod_stage1),
    .bod_stage2(bod_stage2), .osc_running(osc), .boot_strap_high(sh), .boot_strap_low(sl),
    .eint(eint), .power_down(power_down), .chip_reset_n(crn), .cpu_hold(hold),
    .fetch_addr(fa), .ext_bus_width(bw), .cs_swap(cs), .vec_map(vm), .addr_gpio_sel(gs),
    .main_osc_sel(mos), .pll_sel(pll), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
    xfer(0, a, 32'h0);
    cmp(nm, e, r);
  endtask : rd
  task automatic wait_run();
    repeat (100) if (crn !== 1'b1) @(posedge hclk);
    cmp("chip_reset_n", 1, crn);
  endtask : wait_run
  task automatic wake(input int e);
    power_down <= 1;
    eint <= 4'h1;
    repeat (20) if (hold !== 1'b1) @(posedge hclk);
    power_down <= 0;
    eint <= 4'h0;
    n = 0;
    while (hold === 1'b1 && n < 100)
    begin
      @(posedge hclk);
      n++;
    end
    cmp("wake_len", e, n);
  endtask : wake
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    finish_test();
  end
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    wait_run();
    cmp("fetch_addr", 32'h81000000, fa);
    cmp("bus_width", 2'h2, bw);
    cmp("gpio_hi", 4'hf, gs[25:22]);
    cmp("gpio_lo", 0, gs[19:0]);
    cmp("cs_swap", 1, cs);
    cmp("vec_map", 2'h2, vm);
    for (int c = 0; c < 4; c++)
    begin
      xfer(1, 32'h14, c);
      rd(32'h14, (c == 3) ? 2 : c, "vmap");
    end
    rd(32'h20, 0, "unmapped");
    xfer(1, 32'h0c, 32'h1);
    bod_stage1 <= 1;
    repeat (6) @(posedge hclk);
    rd(32'h04, {26'h0, RBBC_ST_RUN, 2'h2}, "stat_bod1");
    cmp("irq", 1, irq);
    bod_stage1 <= 0;
    repeat (4) @(posedge hclk);
    xfer(1, 32'h08, 32'h1);
    repeat (3) @(posedge hclk);
    cmp("irq_clr", 0, irq);
    bod_stage2 <= 1;
    repeat (10) @(posedge hclk);
    cmp("no_bor", 1, crn);
    xfer(1, 32'h0, 32'h1);
    repeat (10) @(posedge hclk);
    cmp("bor", 0, crn);
    bod_stage2 <= 0;
    wait_run();
    xfer(1, 32'h18, 32'h1);
    wake(4);
    rd(32'h08, 32'h2, "wake_stat");
    xfer(1, 32'h0, 32'h2);
    wake(WM);
    cmp("main_osc", 0, mos);
    wdt_reset <= 1;
    @(posedge hclk);
    wdt_reset <= 0;
    repeat (3) @(posedge hclk);
    cmp("wdt", 0, crn);
    wait_run();
    ext_reset_n <= 0;
    repeat (5) @(posedge hclk);
    cmp("pin", 0, crn);
    ext_reset_n <= 1;
    wait_run();
    finish_test();
  end
endmodule : testbench
bind rbbc_top rbbc_props #(.WAKE_MAIN(WAKE_MAIN)) i_rbbc_props (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .ext_reset_n(ext_reset_n), .wdt_reset(wdt_reset),
  .osc_running(osc_running), .chip_reset_n(chip_reset_n), .cpu_hold(cpu_hold),
  .fetch_addr(fetch_addr), .cs_swap(cs_swap), .vec_map(vec_map),
  .main_osc_sel(main_osc_sel), .pll_sel(pll_sel));
